//--- design/wdt_params.svh
// constants for the watchdog, power and reset block
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_POWER_CONTROL 8'h87
`define IDX_WATCHDOG_CONTROL 8'h8F
`define IDX_SERIAL_BUFFER 8'h99
`define ADDR_W 12

// watchdog_control fields
`define CTRL_RUN_BIT 7
`define CTRL_RESTART_BIT 6
`define CTRL_IDLE_RUN_BIT 5
`define CTRL_PS_HI 2
`define CTRL_PS_LO 0
`define CTRL_RESET 8'h00

// power_control fields
`define PWRC_POWER_OFF_BIT 4
`define PWRC_FLAG1_BIT 3
`define PWRC_FLAG0_BIT 2
`define PWRC_DOWN_BIT 1
`define PWRC_IDLE_BIT 0
`define PWRC_RESET 8'h00

// values loaded on reset outside this block
`define PORT_RESET_VAL 8'hFF
`define STACK_RESET_VAL 8'h07

// timing in oscillator periods and machine cycles
`define OSC_PER_MC 4'hC
`define LAST_PHASE 4'hB
`define SAMPLE_PHASE 4'h9
`define RST_SAMPLES_NEEDED 2'h2
`define WDT_RST_HOLD_MC 2'h2
`define TIMER_W 14
`define PRESCALE_W 8

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- design/wdt_pkg.sv
// types for the watchdog, power and reset block
package wdt_pkg;

  typedef enum logic [2:0] {
    PWR_RUN  = 3'b001,
    PWR_IDLE = 3'b010,
    PWR_DOWN = 3'b100
  } power_state_t;

  typedef enum logic [3:0] {
    SEL_NONE  = 4'b0001,
    SEL_POWER  = 4'b0010,
    SEL_WCTRL = 4'b0100,
    SEL_SERIAL  = 4'b1000
  } reg_sel_t;

endpackage : wdt_pkg

//--- design/clock_phase_gen.sv
// oscillator phase counter: internal clock, machine cycle, sample slot
`timescale 1ns/1ps
`include "wdt_params.svh"
module clock_phase_gen (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // oscillator gate
  input wire logic osc_run,
  // enables
  output logic int_tick,
  output logic mc_tick,
  output logic sample_tick
);

  logic [3:0] phase_r;

  // one clk_sys cycle stands for one oscillator period
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_r <= 4'h0;
    end else if (osc_run) begin
      if (phase_r == `LAST_PHASE) begin
        phase_r <= 4'h0;
      end else begin
        phase_r <= phase_r + 4'h1;
      end
    end
  end

  // divide by two: internal clock ticks on every second period
  assign int_tick = osc_run & phase_r[0];
  assign mc_tick = osc_run & (phase_r == `LAST_PHASE);
  assign sample_tick = osc_run & (phase_r == `SAMPLE_PHASE);

endmodule : clock_phase_gen

//--- design/wdt_counter.sv
// watchdog prescaler and 14-bit timer
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_counter (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic count_en,
  input wire logic [2:0] ps_sel,
  // event
  output logic timeout
);

  logic [`PRESCALE_W-1:0] pre_r;
  logic [`TIMER_W-1:0] timer_r;
  logic [`PRESCALE_W-1:0] mask;
  logic pre_hit;

  // ratio 2^(code+1): prescaler wraps when its low code+1 bits are ones
  genvar i;
  generate
    for (i = 0; i < `PRESCALE_W; i = i + 1) begin : g_mask
      assign mask[i] = (3'(i) <= ps_sel);
    end
  endgenerate

  assign pre_hit = &(pre_r | ~mask);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_r <= '0;
      timer_r <= '0;
      timeout <= 1'b0;
    end else if (clear) begin
      pre_r <= '0;
      timer_r <= '0;
      timeout <= 1'b0;
    end else if (count_en) begin
      pre_r <= pre_hit ? '0 : pre_r + 1'b1;
      if (pre_hit) begin
        timer_r <= timer_r + 1'b1;
      end
      timeout <= pre_hit & (&timer_r);
    end else begin
      timeout <= 1'b0;
    end
  end

endmodule : wdt_counter

//--- design/watchdog_with_power_and_reset.sv
// watchdog, power management and reset sampling with an axi4-lite slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "wdt_params.svh"
module watchdog_with_power_and_reset
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system pins
  input wire logic ext_reset_in,
  input wire logic irq_in,
  // clock gates and reset out
  output logic osc_run,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic sys_reset,
  output logic [7:0] port_load_value,
  output logic [7:0] stack_load_value
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic reg_sel_t decode(input logic [`ADDR_W-1:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0 && a[`ADDR_W-1:10] == '0) begin
      case (a[9:2])
        `IDX_POWER_CONTROL: s = SEL_POWER;
        `IDX_WATCHDOG_CONTROL: s = SEL_WCTRL;
        `IDX_SERIAL_BUFFER: s = SEL_SERIAL;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : decode

  logic aw_hold_r, w_hold_r;
  logic aw_hold_nxt, w_hold_nxt, bvalid_nxt, rvalid_nxt;
  logic [`ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_lane_r;
  logic wr_do, wr_lane0, rd_take;
  reg_sel_t wr_sel, rd_sel;

  logic run_r, restart_r, idle_run_r;
  logic [2:0] ps_r;
  logic power_off_r;
  logic [1:0] gf_r;
  logic [7:0] serial_buf_r;
  power_state_t pwr_r;
  logic [1:0] rst_cnt_r;
  logic [1:0] hold_cnt_r;
  logic int_tick, mc_tick, sample_tick, timeout;
  logic wdt_count_en, wdt_clear;
  logic [7:0] ctrl_rd, pwrc_rd;

  assign wr_do = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  assign wr_sel = decode(aw_addr_r);
  assign wr_lane0 = wr_do & w_lane_r;
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign rd_sel = decode(s_axi_araddr);

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  // only one write in flight: ready stays low until the response is taken
  assign aw_hold_nxt = wr_do ? 1'b0
                     : (aw_hold_r | (s_axi_awvalid & s_axi_awready));
  assign w_hold_nxt = wr_do ? 1'b0
                    : (w_hold_r | (s_axi_wvalid & s_axi_wready));
  assign bvalid_nxt = wr_do | (s_axi_bvalid & ~s_axi_bready);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      s_axi_awready <= ~aw_hold_nxt & ~bvalid_nxt;
      s_axi_wready <= ~w_hold_nxt & ~bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (wr_do) begin
        s_axi_bresp <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_addr_r <= '0;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  assign rvalid_nxt = rd_take | (s_axi_rvalid & ~s_axi_rready);
  assign ctrl_rd = {run_r, restart_r, idle_run_r, 2'b00, ps_r};
  assign pwrc_rd = {3'b000, power_off_r, gf_r, 1'b0, pwr_r == PWR_IDLE};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (rd_take) begin
        s_axi_rresp <= (rd_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        case (rd_sel)
          SEL_POWER: s_axi_rdata <= {24'h0, pwrc_rd};
          SEL_WCTRL: s_axi_rdata <= {24'h0, ctrl_rd};
          SEL_SERIAL: s_axi_rdata <= {24'h0, serial_buf_r};
          default: s_axi_rdata <= 32'h0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // watchdog control
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_r <= 1'b0;
      idle_run_r <= 1'b0;
      ps_r <= 3'h0;
    end else if (sys_reset) begin
      run_r <= 1'b0;
      idle_run_r <= 1'b0;
      ps_r <= 3'h0;
    end else if (wr_lane0 && wr_sel == SEL_WCTRL) begin
      run_r <= w_data_r[`CTRL_RUN_BIT];
      idle_run_r <= w_data_r[`CTRL_IDLE_RUN_BIT];
      ps_r <= w_data_r[`CTRL_PS_HI:`CTRL_PS_LO];
    end
  end

  // a new write of one wins over the self-clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      restart_r <= 1'b0;
    end else if (sys_reset) begin
      restart_r <= 1'b0;
    end else if (wr_lane0 && wr_sel == SEL_WCTRL &&
                 w_data_r[`CTRL_RESTART_BIT]) begin
      restart_r <= 1'b1;
    end else if (mc_tick) begin
      restart_r <= 1'b0;
    end
  end

  // restart lands on the next machine cycle boundary, not the write cycle
  assign wdt_clear = sys_reset | (restart_r & mc_tick);
  assign wdt_count_en = mc_tick & run_r & ~restart_r &
                        ((pwr_r == PWR_RUN) |
                         ((pwr_r == PWR_IDLE) & idle_run_r));

  wdt_counter u_counter (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(wdt_clear),
    .count_en(wdt_count_en),
    .ps_sel(ps_r),
    .timeout(timeout)
  );

  // ---------------------------------------------------------------
  // power control
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr_r <= PWR_RUN;
    end else if (sys_reset) begin
      pwr_r <= PWR_RUN;
    end else begin
      case (pwr_r)
        PWR_RUN: begin
          if (wr_lane0 && wr_sel == SEL_POWER) begin
            if (w_data_r[`PWRC_DOWN_BIT]) begin
              pwr_r <= PWR_DOWN;
            end else if (w_data_r[`PWRC_IDLE_BIT]) begin
              pwr_r <= PWR_IDLE;
            end
          end
        end
        PWR_IDLE: begin
          if (irq_in) begin
            pwr_r <= PWR_RUN;
          end else if (wr_lane0 && wr_sel == SEL_POWER &&
                       w_data_r[`PWRC_DOWN_BIT]) begin
            pwr_r <= PWR_DOWN;
          end
        end
        PWR_DOWN: pwr_r <= PWR_DOWN;
        default: pwr_r <= PWR_RUN;
      endcase
    end
  end

  // power-off flag survives every reset but the power-on one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_off_r <= 1'b1;
      gf_r <= 2'b00;
    end else if (sys_reset) begin
      gf_r <= 2'b00;
    end else if (wr_lane0 && wr_sel == SEL_POWER) begin
      power_off_r <= w_data_r[`PWRC_POWER_OFF_BIT];
      gf_r <= {w_data_r[`PWRC_FLAG1_BIT], w_data_r[`PWRC_FLAG0_BIT]};
    end
  end

  // serial buffer is data, deliberately untouched by any reset
  always_ff @(posedge clk_sys) begin
    if (wr_lane0 && wr_sel == SEL_SERIAL) begin
      serial_buf_r <= w_data_r;
    end
  end

  // ---------------------------------------------------------------
  // clocks and reset generation
  // ---------------------------------------------------------------
  clock_phase_gen u_phase (
    .clk_sys(clk_sys),
    .rst(rst),
    .osc_run(osc_run),
    .int_tick(int_tick),
    .mc_tick(mc_tick),
    .sample_tick(sample_tick)
  );

  // a high reset pin wakes the oscillator so the sampler can see it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_run <= 1'b1;
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
    end else begin
      osc_run <= (pwr_r != PWR_DOWN) | ext_reset_in;
      cpu_clk_en <= int_tick & (pwr_r == PWR_RUN);
      periph_clk_en <= int_tick & (pwr_r != PWR_DOWN);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rst_cnt_r <= 2'h0;
    end else if (sample_tick) begin
      if (!ext_reset_in) begin
        rst_cnt_r <= 2'h0;
      end else if (rst_cnt_r != `RST_SAMPLES_NEEDED) begin
        rst_cnt_r <= rst_cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_cnt_r <= 2'h0;
    end else if (timeout & run_r) begin
      hold_cnt_r <= `WDT_RST_HOLD_MC;
    end else if (mc_tick && hold_cnt_r != 2'h0) begin
      hold_cnt_r <= hold_cnt_r - 2'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sys_reset <= 1'b0;
      port_load_value <= `PORT_RESET_VAL;
      stack_load_value <= `STACK_RESET_VAL;
    end else begin
      sys_reset <= (rst_cnt_r == `RST_SAMPLES_NEEDED) |
                   (hold_cnt_r != 2'h0);
      port_load_value <= `PORT_RESET_VAL;
      stack_load_value <= `STACK_RESET_VAL;
    end
  end

endmodule : watchdog_with_power_and_reset

//--- testbench/watchdog_with_power_and_reset_asserts.sv
// checker for the watchdog, power and reset block
`timescale 1ns/1ps
`include "wdt_params.svh"
module watchdog_with_power_and_reset_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register read path
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // system pins and gates
  input wire logic ext_reset_in,
  input wire logic irq_in,
  input wire logic osc_run,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic sys_reset,
  input wire logic [7:0] port_load_value,
  input wire logic [7:0] stack_load_value
);
  localparam logic [`ADDR_W-1:0] A_CTRL = {2'h0, `IDX_WATCHDOG_CONTROL, 2'h0};
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------
  // reset pin hold counter
  // ----------------------------------------------------------
  // saturates so a long hold never wraps back under the bound
  logic [4:0] ext_cnt_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      ext_cnt_r <= 5'h00;
    else if (!ext_reset_in)
      ext_cnt_r <= 5'h00;
    else if (ext_cnt_r != 5'h1F)
      ext_cnt_r <= ext_cnt_r + 5'h01;
  end
  a_cpu_gated: assert property (cpu_clk_en |-> periph_clk_en)
    else $error("processor clock ran without peripheral clock");
  a_clk_half: assert property (periph_clk_en |=> !periph_clk_en)
    else $error("internal clock not divided by two");
  a_pd_stops: assert property (!osc_run |-> !periph_clk_en && !cpu_clk_en)
    else $error("clock enable while oscillator stopped");
  a_pd_holds: assert property (!osc_run && !ext_reset_in |=> !osc_run)
    else $error("power-down left without reset");
  a_osc_wake: assert property (ext_reset_in |=> osc_run)
    else $error("oscillator not running while reset pin high");
  a_ext_taken: assert property (ext_cnt_r >= 5'h1E |-> sys_reset)
    else $error("held reset pin did not reset the system");
  a_load_values: assert property (port_load_value == 8'hFF &&
    stack_load_value == 8'h07)
    else $error("port or stack load value wrong");
  a_idle_wake: assert property (periph_clk_en && !cpu_clk_en && irq_in &&
    !sys_reset |-> ##[1:6] cpu_clk_en)
    else $error("interrupt did not end idle");
  a_rsvd_zero: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == A_CTRL |=> s_axi_rvalid &&
    s_axi_rdata[4:3] == 2'h0 && s_axi_rdata[31:8] == 24'h000000)
    else $error("unused control bits read non-zero");
endmodule : watchdog_with_power_and_reset_asserts

bind watchdog_with_power_and_reset watchdog_with_power_and_reset_asserts chk (
  .clk_sys, .rst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .ext_reset_in, .irq_in, .osc_run,
  .cpu_clk_en, .periph_clk_en, .sys_reset, .port_load_value,
  .stack_load_value);

//--- testbench/test_watchdog_with_power_and_reset.sv
// self-checking bench for the watchdog, power and reset block
`timescale 1ns/1ps
`include "wdt_params.svh"
module test_watchdog_with_power_and_reset;
  localparam logic [11:0] A_PWRC = {2'h0, `IDX_POWER_CONTROL, 2'h0};
  localparam logic [11:0] A_CTRL = {2'h0, `IDX_WATCHDOG_CONTROL, 2'h0};
  localparam logic [11:0] A_SERIAL = {2'h0, `IDX_SERIAL_BUFFER, 2'h0};
  logic clk_sys, rst;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, ext_reset_in, irq_in;
  logic osc_run, cpu_clk_en, periph_clk_en, sys_reset;
  logic [7:0] port_load_value, stack_load_value;
  int err_count, tests_run, n_cpu, n_per;

  watchdog_with_power_and_reset dut (.*);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  task automatic rdc(input string n, input logic [11:0] a,
                     input logic [31:0] e);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(n, rd, e);
  endtask : rdc

  // counts clock-enable pulses over a fixed span
  task automatic cnt(input int n);
    n_cpu = 0;
    n_per = 0;
    repeat (n) begin
      @(posedge clk_sys);
      if (cpu_clk_en === 1'b1) n_cpu++;
      if (periph_clk_en === 1'b1) n_per++;
    end
  endtask : cnt
  // ----------------------------------------------------------
  // sequence
  // ----------------------------------------------------------
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, ext_reset_in, irq_in} = 4'h0;
    s_axi_wstrb = 4'h1;
    err_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    chk("port", {24'h0, port_load_value}, 32'hFF);
    chk("stack", {24'h0, stack_load_value}, 32'h07);
    rdc("ctrl reset", A_CTRL, 32'h00);
    rdc("pwrc reset", A_PWRC, 32'h10);
    wr(A_CTRL, 8'hBF, 2'h0);
    // BF sets every control bit but restart; unused bits 4:3 must read back zero
    repeat (12) @(posedge clk_sys);
    rdc("ctrl unused", A_CTRL, 32'hA7);
    for (int c = 0; c < 8; c++) begin
      wr(A_CTRL, 8'h80 | 8'(c), 2'h0);
      rdc("ctrl select", A_CTRL, 32'h80 | 32'(c));
    end
    wr(A_CTRL, 8'hC0, 2'h0);
    repeat (14) @(posedge clk_sys);
    rdc("restart", A_CTRL, 32'h80);
    wr(A_CTRL + 12'h1, 8'h00, 2'h2);
    wr(12'h100, 8'h55, 2'h2);
    rdc("unmapped", 12'h100, 32'h0);
    chk("rresp", {30'h0, rr}, 32'h2);
    rdc("ctrl kept", A_CTRL, 32'h80);
    cnt(24);
    chk("run cpu", 32'(n_cpu), 32'hC);
    wr(A_PWRC, 8'h11, 2'h0);
    cnt(24);
    chk("idle cpu", 32'(n_cpu), 32'h0);
    chk("idle per", 32'(n_per), 32'hC);
    rdc("idle flag", A_PWRC, 32'h11);
    irq_in <= 1'b1;
    repeat (8) @(posedge clk_sys);
    cnt(24);
    chk("wake cpu", 32'(n_cpu), 32'hC);
    irq_in <= 1'b0;
    wr(A_CTRL, 8'h85, 2'h0);
    ext_reset_in <= 1'b1;
    repeat (12) @(posedge clk_sys);
    ext_reset_in <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rdc("one sample", A_CTRL, 32'h85);
    wr(A_SERIAL, 8'h5A, 2'h0);
    wr(A_PWRC, 8'h1E, 2'h0);
    irq_in <= 1'b1;
    cnt(24);
    chk("down osc", {31'h0, osc_run}, 32'h0);
    chk("down per", 32'(n_per), 32'h0);
    irq_in <= 1'b0;
    ext_reset_in <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk("ext reset", {31'h0, sys_reset}, 32'h1);
    ext_reset_in <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk("reset end", {31'h0, sys_reset}, 32'h0);
    rdc("ctrl after", A_CTRL, 32'h00);
    rdc("pwrc after", A_PWRC, 32'h10);
    rdc("serial kept", A_SERIAL, 32'h5A);
    cnt(24);
    chk("down exit", 32'(n_cpu), 32'hC);
    close_out();
  end

  // bench needs a few hundred cycles; this is ample
  initial begin
    #(8 * 20000);
    err_count++;
    close_out();
  end
endmodule : test_watchdog_with_power_and_reset
